// File: hw/dtmr_pkg.sv
// Package with register map, field layout, reset values and codes of the dual timer.
package dtmr_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_GLOBAL_INT = 8'h0B;
    localparam logic [7:0] IDX_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_WIDE_LOW = 8'h0E;
    localparam logic [7:0] IDX_WIDE_HIGH = 8'h0F;
    localparam logic [7:0] IDX_WIDE_CTRL = 8'h10;
    localparam logic [7:0] IDX_PERIOD_COUNT = 8'h11;
    localparam logic [7:0] IDX_PERIOD_CTRL = 8'h12;
    localparam logic [7:0] IDX_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_PERIOD_MATCH = 8'h92;

    // Wide timer control fields.
    localparam int WIDE_RUN_BIT = 0;
    localparam int WIDE_SRC_BIT = 1;
    localparam int WIDE_NOSYNC_BIT = 2;
    localparam int WIDE_OSC_BIT = 3;
    localparam int WIDE_PS_LSB = 4;
    localparam logic [7:0] WIDE_CTRL_MASK = 8'h3F;

    // Period timer control fields.
    localparam int PERIOD_PS_LSB = 0;
    localparam int PERIOD_RUN_BIT = 2;
    localparam int POST_LSB = 3;
    localparam logic [7:0] PERIOD_CTRL_MASK = 8'h7F;

    // Flag and enable positions, global control bits kept.
    localparam int WIDE_FLAG_BIT = 0;
    localparam int PERIOD_FLAG_BIT = 1;
    localparam logic [7:0] FLAG_MASK = 8'h03;
    localparam logic [7:0] GLOBAL_INT_MASK = 8'hC0;

    // Reset values.
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PERIOD_MATCH = 8'hFF;

    // Compare mode code that produces the special event trigger.
    localparam logic [3:0] CMP_SPECIAL_EVENT = 4'hB;
    localparam logic [15:0] WIDE_TOP = 16'hFFFF;

    // Compare unit view of the wide timer.
    typedef struct packed {
        logic [3:0] mode;
        logic [15:0] value;
    } dtmr_cmp_t;

endpackage

// File: hw/dtmr_top.sv
// Dual timer: 16-bit wide timer and 8-bit period timer behind a Wishbone slave.
//
// Functional notes
// - Each byte read of the wide count returns that byte of the live count; the other byte is not latched.
// - Oscillator enable bit turns on the low-power crystal oscillator.
// - Special event trigger compare mode resets the wide count.
// - Trigger reset never sets the wide overflow flag.
// - Trigger reset is not applied in asynchronous counter mode.
// - A count write in the trigger cycle wins over the trigger reset.
// - Compare value pair acts as wide timer period, restarting count at zero.
// - Wide count bytes are never cleared by any reset.
// - Wide control clears on power-on or brown-out reset only.
// - Writing either wide count byte clears the wide prescaler.
// - Period timer prescaler: 00 gives 1:1, 01 gives 1:4, 1x gives 1:16.
// - Period count runs to the match value, then returns to zero signalling match.
// - Period match register is read-write and resets to all ones.
// - Period count is read-write and cleared by any reset.
// - Four-bit postscaler divides matches 1 to 16 and sets period flag.
// - Period run bit enables the period timer; control bit 7 reads zero.
// - Period prescaler and postscaler clear on count write, control write, reset.
// - Writing period control leaves the period count unchanged.
// - Pre-postscaler period match goes out to the serial port.
// - Wide count wraps from all ones to zero and sets overflow flag.
// - Wide prescaler: 11 gives 1:8, 10 1:4, 01 1:2, 00 1:1.
// - Wide clock source bit selects instruction clock or pin rising edges.
// - Wide run bit enables counting when set, stops when clear.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module dtmr_top
    import dtmr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    input wire logic porReset,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Wide timer clock pins and compare unit.
    input wire logic crystalInputPin,
    input wire logic extClockPin,
    input wire dtmr_cmp_t compareUnit,
    output logic lowPowerOscEnable,
    // Events out.
    output logic periodMatchOut,
    output logic interruptRequest
);

    ////////////////////////////////////////////////////////////////////////////////////
    // Register bus.

    logic [7:0] globalInt;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [15:0] wideCount;
    logic [7:0] wideCtrl;
    logic [7:0] periodCount;
    logic [7:0] periodCtrl;
    logic [7:0] periodMatch;
    logic busWrite;
    logic [7:0] wrData;
    logic [7:0] rdData;

    // True when the current write targets the given register index.
    function automatic logic hit(input logic [7:0] idx);
        return busWrite && (adr_i[9:2] == idx);
    endfunction

    assign busWrite = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    assign wrData = dat_i[7:0];

    always_ff @(posedge clk) begin
        if (srst) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    always_comb begin
        case (adr_i[9:2])
            IDX_GLOBAL_INT: rdData = globalInt;
            IDX_FLAGS: rdData = flags;
            IDX_ENABLES: rdData = enables;
            IDX_WIDE_LOW: rdData = wideCount[7:0];
            IDX_WIDE_HIGH: rdData = wideCount[15:8];
            IDX_WIDE_CTRL: rdData = wideCtrl;
            IDX_PERIOD_COUNT: rdData = periodCount;
            IDX_PERIOD_CTRL: rdData = periodCtrl;
            IDX_PERIOD_MATCH: rdData = periodMatch;
            default: rdData = RST_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dat_o <= 32'h0000_0000;
        end else if (cyc_i && stb_i && !we_i && !ack_o) begin
            dat_o <= {24'h00_0000, rdData};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            globalInt <= RST_ZERO;
            enables <= RST_ZERO;
        end else begin
            if (hit(IDX_GLOBAL_INT)) begin
                globalInt <= wrData & GLOBAL_INT_MASK;
            end
            if (hit(IDX_ENABLES)) begin
                enables <= wrData & FLAG_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Wide timer.

    logic [2:0] widePre;
    logic [2:0] widePreLimit;
    logic extPrev;
    logic srcPin;
    logic wideTickIn;
    logic wideInc;
    logic wideWrite;
    logic specialEvent;
    logic wideOverflow;

    always_ff @(posedge clk) begin
        if (srst && porReset) begin
            wideCtrl <= RST_ZERO;
        end else if (hit(IDX_WIDE_CTRL)) begin
            wideCtrl <= wrData & WIDE_CTRL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (srst && porReset) begin
            lowPowerOscEnable <= 1'b0;
        end else begin
            lowPowerOscEnable <= wideCtrl[WIDE_OSC_BIT];
        end
    end

    // Crystal input is the count source while the oscillator runs.
    assign srcPin = wideCtrl[WIDE_OSC_BIT] ? crystalInputPin : extClockPin;

    always_ff @(posedge clk) begin
        if (srst) begin
            extPrev <= 1'b0;
        end else begin
            extPrev <= srcPin;
        end
    end

    assign wideTickIn = wideCtrl[WIDE_RUN_BIT] &&
        (wideCtrl[WIDE_SRC_BIT] ? (srcPin && !extPrev) : 1'b1);
    assign widePreLimit = 3'((4'd1 << wideCtrl[WIDE_PS_LSB +: 2]) - 4'd1);
    assign wideWrite = hit(IDX_WIDE_LOW) || hit(IDX_WIDE_HIGH);
    assign wideInc = wideTickIn && (widePre == widePreLimit);

    always_ff @(posedge clk) begin
        if (srst || wideWrite) begin
            widePre <= 3'd0;
        end else if (wideTickIn) begin
            widePre <= wideInc ? 3'd0 : widePre + 3'd1;
        end
    end

    assign specialEvent = (compareUnit.mode == CMP_SPECIAL_EVENT) &&
        (wideCount == compareUnit.value) &&
        !(wideCtrl[WIDE_SRC_BIT] && wideCtrl[WIDE_NOSYNC_BIT]);
    assign wideOverflow = wideInc && (wideCount == WIDE_TOP) && !wideWrite &&
        !specialEvent;

    // No reset term: the count keeps its value through every reset.
    always_ff @(posedge clk) begin
        if (wideWrite) begin
            if (hit(IDX_WIDE_LOW)) begin
                wideCount[7:0] <= wrData;
            end
            if (hit(IDX_WIDE_HIGH)) begin
                wideCount[15:8] <= wrData;
            end
        end else if (specialEvent) begin
            wideCount <= 16'h0000;
        end else if (wideInc) begin
            wideCount <= wideCount + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Period timer.

    logic [3:0] periodPre;
    logic [3:0] periodPreLimit;
    logic [3:0] postCount;
    logic periodCountWrite;
    logic periodCtrlWrite;
    logic periodInc;
    logic periodWrap;
    logic postFire;

    assign periodCountWrite = hit(IDX_PERIOD_COUNT);
    assign periodCtrlWrite = hit(IDX_PERIOD_CTRL);
    assign periodPreLimit = periodCtrl[PERIOD_PS_LSB + 1] ? 4'hF :
        (periodCtrl[PERIOD_PS_LSB] ? 4'h3 : 4'h0);
    assign periodInc = periodCtrl[PERIOD_RUN_BIT] && (periodPre == periodPreLimit) &&
        !periodCountWrite && !periodCtrlWrite;
    assign periodWrap = periodInc && (periodCount == periodMatch);
    assign postFire = periodWrap && (postCount == periodCtrl[POST_LSB +: 4]);

    always_ff @(posedge clk) begin
        if (srst) begin
            periodCtrl <= RST_ZERO;
        end else if (periodCtrlWrite) begin
            periodCtrl <= wrData & PERIOD_CTRL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            periodMatch <= RST_PERIOD_MATCH;
        end else if (hit(IDX_PERIOD_MATCH)) begin
            periodMatch <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || periodCountWrite || periodCtrlWrite) begin
            periodPre <= 4'h0;
        end else if (periodCtrl[PERIOD_RUN_BIT]) begin
            periodPre <= (periodPre == periodPreLimit) ? 4'h0 : periodPre + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || periodCountWrite || periodCtrlWrite) begin
            postCount <= 4'h0;
        end else if (periodWrap) begin
            postCount <= postFire ? 4'h0 : postCount + 4'h1;
        end
    end

    // A control write does not touch the count.
    always_ff @(posedge clk) begin
        if (srst) begin
            periodCount <= RST_ZERO;
        end else if (periodCountWrite) begin
            periodCount <= wrData;
        end else if (periodWrap) begin
            periodCount <= RST_ZERO;
        end else if (periodInc) begin
            periodCount <= periodCount + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            periodMatchOut <= 1'b0;
        end else begin
            periodMatchOut <= periodWrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Flags and interrupt request.

    logic [7:0] next_flags;

    // Hardware set wins over a software clear in the same cycle.
    always_comb begin
        next_flags = hit(IDX_FLAGS) ? (wrData & FLAG_MASK) : flags;
        if (wideOverflow) begin
            next_flags[WIDE_FLAG_BIT] = 1'b1;
        end
        if (postFire) begin
            next_flags[PERIOD_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flags <= RST_ZERO;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            interruptRequest <= 1'b0;
        end else begin
            interruptRequest <= |(flags & enables);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Both count bytes loaded since power-on; the count has no reset, so it is unknown before.
    logic [1:0] wideLoaded;
    always_ff @(posedge clk) begin
        if (srst && porReset) begin
            wideLoaded <= 2'b00;
        end else begin
            wideLoaded <= wideLoaded | {hit(IDX_WIDE_HIGH), hit(IDX_WIDE_LOW)};
        end
    end

    sequence s_period_wrap;
        periodInc && (periodCount == periodMatch);
    endsequence

    sequence s_wrap_seen;
        (periodCount == RST_ZERO) && periodMatchOut;
    endsequence

    chk_period_wrap_zero: assert property (s_period_wrap |=> s_wrap_seen)
        else $error("Period count did not return to zero with a match pulse.");

    chk_ctrl_write_keeps: assert property (periodCtrlWrite && !periodCountWrite
        |=> periodCount == $past(periodCount))
        else $error("Period control write changed the count.");

    chk_prescale_cleared: assert property (periodCountWrite |=> periodPre == 4'h0
        && postCount == 4'h0)
        else $error("Period prescaler or postscaler not cleared by count write.");

    chk_trigger_no_flag: assert property (specialEvent && !flags[WIDE_FLAG_BIT]
        && !hit(IDX_FLAGS) |=> !flags[WIDE_FLAG_BIT])
        else $error("Trigger reset set the wide overflow flag.");

    chk_trigger_clears: assert property (specialEvent && !wideWrite
        |=> wideCount == 16'h0000)
        else $error("Trigger did not reset the wide count.");

    chk_write_wins: assert property (specialEvent && hit(IDX_WIDE_LOW)
        |=> wideCount[7:0] == $past(wrData))
        else $error("Trigger reset won over a count write.");

    chk_overflow_flag: assert property (wideOverflow
        |=> flags[WIDE_FLAG_BIT] && wideCount == 16'h0000)
        else $error("Wide wrap did not set the overflow flag.");

    chk_wide_stopped: assert property ((&wideLoaded) && !wideCtrl[WIDE_RUN_BIT]
        && !wideWrite && !specialEvent |=> $stable(wideCount))
        else $error("Stopped wide timer changed its count.");

    chk_irq_follows: assert property ((|(flags & enables)) ##1 (|(flags & enables))
        |-> interruptRequest)
        else $error("Interrupt request missing with flag and enable set.");

    chk_match_reset: assert property ($fell(srst) |-> periodMatch == RST_PERIOD_MATCH)
        else $error("Period match value not all ones after reset.");

endmodule // dtmr_top

// File: dv/dtmr_cmp_model.sv
// Compare unit model that drives the wide timer's compare port.
`timescale 1ns/1ps
module dtmr_cmp_model
    import dtmr_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Settings from the bench.
    input wire logic [3:0] modeSet,
    input wire logic [15:0] valueSet,
    // Compare state seen by the timer.
    output dtmr_cmp_t compareUnit
);
    // Mode and value pair update once a cycle, as a register would.
    always_ff @(posedge clk) begin
        compareUnit.mode <= modeSet;
        compareUnit.value <= valueSet;
    end
endmodule // dtmr_cmp_model

// File: dv/dtmr_top_tb.sv
// Self-checking bench of the dual timer over its Wishbone port.
`timescale 1ns/1ps
module dtmr_top_tb
    import dtmr_pkg::*;
;
    logic clk;
    logic srst = 1'b1;
    logic porReset = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] datO;
    logic ackO;
    logic xtal = 1'b0;
    logic extPin = 1'b0;
    logic [3:0] pinCnt = 4'h0;
    logic [3:0] modeSet = 4'h0;
    logic [15:0] valueSet = 16'h0000;
    dtmr_cmp_t compareUnit;
    logic oscEn;
    logic periodMatchOut;
    logic irq;
    int errTotal = 0;
    int compares = 0;
    int cycles = 0;
    int gapExp [4] = '{3, 12, 48, 48};
    int postCode [3] = '{0, 3, 15};
    logic [31:0] q;
    int c;
    int n;
    dtmr_top dut (.clk(clk), .srst(srst), .porReset(porReset), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(datO), .ack_o(ackO),
        .crystalInputPin(xtal), .extClockPin(extPin), .compareUnit(compareUnit),
        .lowPowerOscEnable(oscEn), .periodMatchOut(periodMatchOut), .interruptRequest(irq));
    dtmr_cmp_model partner (.clk(clk), .modeSet(modeSet), .valueSet(valueSet),
        .compareUnit(compareUnit));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Pin stimulus and hang guard.
    always @(posedge clk) begin
        pinCnt <= pinCnt + 4'h1;
        extPin <= pinCnt[2];
        xtal <= pinCnt[3];
        cycles++;
        if (cycles == 20000) begin
            errTotal++;
            testDone();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            errTotal++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'hF;
        dat <= {24'h00_0000, d};
        do begin
            @(posedge clk);
        end while (ackO !== 1'b1);
        q = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        chk(q, {24'h00_0000, e});
    endtask
    task automatic rst(input logic p);
        srst <= 1'b1;
        porReset <= p;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        porReset <= 1'b0;
        @(posedge clk);
    endtask
    task automatic testDone();
        if (errTotal == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        porReset <= 1'b0;
        @(posedge clk);
        rd(IDX_FLAGS, 8'h00);
        rd(IDX_WIDE_CTRL, 8'h00);
        rd(IDX_PERIOD_COUNT, 8'h00);
        rd(IDX_PERIOD_CTRL, 8'h00);
        rd(IDX_ENABLES, 8'h00);
        rd(IDX_PERIOD_MATCH, 8'hFF);
        rd(8'h20, 8'h00);
        wr(IDX_GLOBAL_INT, 8'hFF);
        rd(IDX_GLOBAL_INT, 8'hC0);
        wr(IDX_PERIOD_CTRL, 8'hFB);
        rd(IDX_PERIOD_CTRL, 8'h7B);
        wr(IDX_PERIOD_COUNT, 8'h55);
        wr(IDX_PERIOD_CTRL, 8'h00);
        rd(IDX_PERIOD_COUNT, 8'h55);
        wr(IDX_PERIOD_MATCH, 8'h02);
        rd(IDX_PERIOD_MATCH, 8'h02);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_PERIOD_CTRL, 8'h04 | 8'(i));
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (periodMatchOut !== 1'b1 && n < 200);
            c = 0;
            do begin
                @(posedge clk);
                c++;
            end while (periodMatchOut !== 1'b1 && c < 200);
            chk(c, gapExp[i]);
        end
        wr(IDX_ENABLES, 8'h02);
        for (int i = 0; i < 3; i++) begin
            wr(IDX_PERIOD_CTRL, 8'(postCode[i] << 3));
            wr(IDX_FLAGS, 8'h00);
            wr(IDX_PERIOD_COUNT, 8'h00);
            wr(IDX_PERIOD_CTRL, 8'(postCode[i] << 3) | 8'h04);
            c = 0;
            n = 0;
            while (irq !== 1'b1 && n < 400) begin
                @(posedge clk);
                n++;
                if (periodMatchOut === 1'b1) c++;
            end
            chk(c, postCode[i] + 1);
        end
        wr(IDX_PERIOD_CTRL, 8'h00);
        repeat (60) @(posedge clk);
        chk(irq, 1'b1);
        rd(IDX_FLAGS, 8'h02);
        wr(IDX_FLAGS, 8'h00);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wr(IDX_WIDE_HIGH, 8'hFF);
        wr(IDX_WIDE_LOW, 8'hF0);
        wr(IDX_ENABLES, 8'h01);
        wr(IDX_WIDE_CTRL, 8'h01);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        wr(IDX_WIDE_CTRL, 8'h00);
        chk(irq, 1'b1);
        rd(IDX_FLAGS, 8'h01);
        rd(IDX_WIDE_HIGH, 8'h00);
        wr(IDX_FLAGS, 8'h00);
        modeSet <= CMP_SPECIAL_EVENT;
        valueSet <= 16'h0010;
        wr(IDX_WIDE_HIGH, 8'h00);
        wr(IDX_WIDE_LOW, 8'h00);
        wr(IDX_WIDE_CTRL, 8'h01);
        repeat (100) @(posedge clk);
        wr(IDX_WIDE_CTRL, 8'h00);
        rd(IDX_WIDE_HIGH, 8'h00);
        wb(1'b0, IDX_WIDE_LOW, 8'h00);
        chk(q <= 32'h0000_0010, 1'b1);
        rd(IDX_FLAGS, 8'h00);
        modeSet <= 4'h0;
        wr(IDX_WIDE_HIGH, 8'h00);
        wr(IDX_WIDE_LOW, 8'h00);
        wr(IDX_WIDE_CTRL, 8'h31);
        repeat (80) @(posedge clk);
        wr(IDX_WIDE_CTRL, 8'h00);
        rd(IDX_WIDE_LOW, 8'h0A);
        wr(IDX_WIDE_LOW, 8'h00);
        wr(IDX_WIDE_CTRL, 8'h31);
        repeat (74) @(posedge clk);
        wr(IDX_WIDE_CTRL, 8'h00);
        rd(IDX_WIDE_LOW, 8'h09);
        wr(IDX_WIDE_LOW, 8'h00);
        wr(IDX_WIDE_CTRL, 8'h03);
        repeat (77) @(posedge clk);
        wr(IDX_WIDE_CTRL, 8'h00);
        rd(IDX_WIDE_LOW, 8'h0A);
        modeSet <= CMP_SPECIAL_EVENT;
        valueSet <= 16'h0003;
        wr(IDX_WIDE_LOW, 8'h00);
        wr(IDX_WIDE_CTRL, 8'h07);
        repeat (77) @(posedge clk);
        wr(IDX_WIDE_CTRL, 8'h00);
        rd(IDX_WIDE_LOW, 8'h0A);
        valueSet <= 16'h0000;
        wr(IDX_WIDE_LOW, 8'h00);
        wr(IDX_WIDE_LOW, 8'h55);
        rd(IDX_WIDE_LOW, 8'h55);
        modeSet <= 4'h0;
        wr(IDX_WIDE_CTRL, 8'h08);
        wr(IDX_WIDE_LOW, 8'h00);
        wr(IDX_WIDE_CTRL, 8'h0B);
        repeat (77) @(posedge clk);
        wr(IDX_WIDE_CTRL, 8'h08);
        rd(IDX_WIDE_LOW, 8'h05);
        wr(IDX_WIDE_CTRL, 8'h08);
        wr(IDX_WIDE_HIGH, 8'h12);
        wr(IDX_WIDE_LOW, 8'h34);
        wr(IDX_PERIOD_MATCH, 8'h07);
        rst(1'b0);
        chk(oscEn, 1'b1);
        rd(IDX_WIDE_CTRL, 8'h08);
        rd(IDX_WIDE_LOW, 8'h34);
        rd(IDX_PERIOD_MATCH, 8'hFF);
        rst(1'b1);
        rd(IDX_WIDE_CTRL, 8'h00);
        chk(oscEn, 1'b0);
        rd(IDX_WIDE_HIGH, 8'h12);
        testDone();
    end
endmodule // dtmr_top_tb
